// ===== src/ubd_engine.sv
`timescale 1ns/10ps
`default_nettype none

module ubd_engine
   import ubd_pkg::*;
#(
   parameter int RAM_BYTES = RAM_SIZE,
   parameter int NUM_EP    = EP_COUNT
)
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [11:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic [7:0]  cpu_wdata,
   output logic [7:0]       cpu_rdata_r,
   input  wire logic        addr_wr,
   input  wire logic [6:0]  addr_wdata,
   output logic [6:0]       device_address_r,
   input  wire logic        bus_reset,
   input  wire logic        suspend_bit,
   input  wire logic        sof_valid,
   input  wire logic [10:0] sof_frame,
   output logic [7:0]       frame_number_low_r,
   output logic [7:0]       frame_number_high_r,
   input  wire logic        tok_valid,
   input  wire ubd_token_t  tok,
   input  wire logic        rx_start,
   input  wire logic        rx_data1,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_end,
   input  wire logic        rx_ok,
   input  wire logic        tx_ready,
   input  wire logic        in_ack,
   input  wire logic        in_timeout,
   output ubd_hs_t          hs_r,
   output logic             tx_valid_r,
   output logic [7:0]       tx_byte_r,
   output logic             tx_last_r,
   output logic             tx_zero_r,
   output logic             tx_data1_r,
   output logic             trn_done_r,
   output logic [7:0]       trn_status_r,
   output logic             stall_event_r
);

   // ---------------------------------------------------------------
   // Storage and transaction state
   // ---------------------------------------------------------------
   logic [7:0]  ram [RAM_BYTES];
   logic [4:0]  epc_r [NUM_EP];
   ubd_state_t  state_r;
   logic [3:0]  ep_r;
   logic [4:0]  dsc_r;
   logic [3:0]  pid_r;
   logic [7:0]  st_r;
   logic [9:0]  max_r;
   logic [11:0] buf_r;
   logic [9:0]  cnt_r;
   logic        tog_ok_r;
   logic        ovf_r;

   // Decisions taken this cycle
   logic [3:0]  cur_ep;
   logic        hshk_on;
   logic        tok_is_in;
   logic        tok_is_setup;
   logic [4:0]  tok_dsc;
   logic [7:0]  tok_stat;
   logic [7:0]  tok_adrh;
   logic [4:0]  ep_sel;
   logic        dir_ok;
   logic        tok_hit;
   logic        hs_raw;
   logic [3:0]  hs_code;
   logic        stall_raw;
   logic        commit;
   logic        rx_wr_ok;
   logic        eng_we;
   logic [11:0] eng_addr;
   logic [7:0]  eng_wdata;
   logic [9:0]  nxt_idx;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Descriptor n starts at base plus 4n, bytes in fixed order
   function automatic logic [11:0] dsc_addr(input logic [4:0] dn, input logic [1:0] ofs);
      dsc_addr = TBL_BASE + {5'h00, dn, 2'h0} + {10'h000, ofs};
   endfunction : dsc_addr

   function automatic logic in_ram(input logic [11:0] a);
      in_ram = (a <= RAM_LAST) && (int'(a) < RAM_BYTES);
   endfunction : in_ram

   // Out-of-range buffer pointers read as zero instead of unknown
   function automatic logic [7:0] ram_rd(input logic [11:0] a);
      if (in_ram(a))
         ram_rd = ram[a];
      else
         ram_rd = BYTE_ZERO;
   endfunction : ram_rd

   // ---------------------------------------------------------------
   // Token qualification and handshake choice
   // ---------------------------------------------------------------
   always_comb
   begin
      cur_ep       = (state_r == S_IDLE) ? tok.endp : ep_r;
      hshk_on      = epc_r[cur_ep][EPC_HSHK];
      tok_is_in    = (tok.pid == PID_IN);
      tok_is_setup = (tok.pid == PID_SETUP);
      tok_dsc      = {tok.endp, tok_is_in};
      tok_stat     = ram_rd(dsc_addr(tok_dsc, DSC_OFS_STAT));
      tok_adrh     = ram_rd(dsc_addr(tok_dsc, DSC_OFS_ADRH));
      ep_sel       = epc_r[tok.endp];
      // Disabled directions never reach the table
      if (tok_is_in)
         dir_ok = ep_sel[EPC_INEN];
      else if (tok.pid == PID_OUT)
         dir_ok = ep_sel[EPC_OUTEN];
      else if (tok_is_setup)
         dir_ok = ep_sel[EPC_OUTEN] &&
                  !(ep_sel[EPC_CONDIS] && ep_sel[EPC_INEN]);
      else
         dir_ok = 1'b0;
      tok_hit = (state_r == S_IDLE) && tok_valid &&
                (tok.addr == device_address_r) && dir_ok;
      hs_raw    = 1'b0;
      hs_code   = PID_ACK;
      stall_raw = 1'b0;
      commit    = 1'b0;
      // IN answers at once when it cannot send data
      if (tok_hit && tok_is_in)
      begin
         if (!tok_stat[ST_OWN])
         begin
            hs_raw  = 1'b1;
            hs_code = PID_NAK;
         end
         else if (tok_stat[ST_BSTL])
         begin
            hs_raw    = 1'b1;
            hs_code   = PID_STALL;
            stall_raw = 1'b1;
         end
      end
      // OUT and SETUP answer after the data packet
      if ((state_r == S_RX) && rx_end && rx_ok)
      begin
         hs_raw = 1'b1;
         if (!st_r[ST_OWN])
            hs_code = PID_NAK;
         else if (st_r[ST_BSTL] && (pid_r != PID_SETUP))
         begin
            hs_code   = PID_STALL;
            stall_raw = 1'b1;
         end
         else if (ovf_r)
            hs_code = PID_NAK;
         else
         begin
            hs_code = PID_ACK;
            commit  = tog_ok_r;
         end
      end
   end

   // Write only inside the limit, only while owned and in sync
   assign rx_wr_ok = rx_valid && (cnt_r != max_r) && st_r[ST_OWN] && tog_ok_r &&
                     (!st_r[ST_BSTL] || (pid_r == PID_SETUP));
   assign nxt_idx  = cnt_r + 10'h001;

   // ---------------------------------------------------------------
   // Engine write port
   // ---------------------------------------------------------------
   always_comb
   begin
      eng_we    = 1'b0;
      eng_addr  = dsc_addr(dsc_r, DSC_OFS_STAT);
      eng_wdata = BYTE_ZERO;
      if ((state_r == S_RX) && rx_wr_ok)
      begin
         eng_we    = 1'b1;
         eng_addr  = buf_r + {2'h0, cnt_r};
         eng_wdata = rx_byte;
      end
      else if (state_r == S_WB_CNT)
      begin
         eng_we    = 1'b1;
         eng_addr  = dsc_addr(dsc_r, DSC_OFS_CNT);
         eng_wdata = cnt_r[7:0];
      end
      else if (state_r == S_WB_STAT)
      begin
         // Status goes last; ownership drops with it
         eng_we    = 1'b1;
         eng_wdata = {1'b0, st_r[ST_TOG], pid_r, cnt_r[9:8]};
      end
   end

   // Both ports write freely; the engine wins a same-cycle clash
   always_ff @(posedge clock)
   begin
      if (cpu_wr && in_ram(cpu_addr))
         ram[cpu_addr] <= cpu_wdata;
      if (eng_we && in_ram(eng_addr))
         ram[eng_addr] <= eng_wdata;
   end

   // ---------------------------------------------------------------
   // Transaction sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r  <= S_IDLE;
         ep_r     <= 4'h0;
         dsc_r    <= 5'h00;
         pid_r    <= 4'h0;
         st_r     <= BYTE_ZERO;
         max_r    <= 10'h000;
         buf_r    <= 12'h000;
         cnt_r    <= 10'h000;
         tog_ok_r <= 1'b0;
         ovf_r    <= 1'b0;
      end
      else if (bus_reset)
         state_r <= S_IDLE;
      else
      begin
         case (state_r)
            S_IDLE:
               if (tok_hit)
               begin
                  ep_r  <= tok.endp;
                  dsc_r <= tok_dsc;
                  pid_r <= tok.pid;
                  st_r  <= tok_stat;
                  max_r <= {tok_stat[1:0], ram_rd(dsc_addr(tok_dsc, DSC_OFS_CNT))};
                  buf_r <= {tok_adrh[3:0], ram_rd(dsc_addr(tok_dsc, DSC_OFS_ADRL))};
                  cnt_r <= 10'h000;
                  if (!tok_is_in)
                     state_r <= S_RX;
                  else if (tok_stat[ST_OWN] && !tok_stat[ST_BSTL])
                     state_r <= S_IN_LOAD;
               end
            S_RX:
               if (tok_valid)
                  state_r <= S_IDLE; // data packet never came
               else if (rx_start)
               begin
                  cnt_r    <= 10'h000;
                  ovf_r    <= 1'b0;
                  // SETUP is taken whatever its toggle
                  tog_ok_r <= !st_r[ST_TOGEN] || (pid_r == PID_SETUP) ||
                              (rx_data1 == st_r[ST_TOG]);
               end
               else if (rx_end)
                  state_r <= commit ? S_WB_CNT : S_IDLE;
               else if (rx_valid)
               begin
                  if (cnt_r == max_r)
                     ovf_r <= 1'b1;
                  else
                     cnt_r <= nxt_idx;
               end
            S_IN_LOAD:
               state_r <= S_IN_SEND;
            S_IN_SEND:
               if (tx_ready && tx_last_r)
               begin
                  cnt_r   <= max_r;
                  state_r <= hshk_on ? S_IN_WAIT : S_WB_CNT;
               end
               else if (tx_ready)
                  cnt_r <= nxt_idx;
            S_IN_WAIT:
               if (in_ack)
                  state_r <= S_WB_CNT;
               else if (in_timeout)
                  state_r <= S_IDLE; // host lost the data; stays armed
            S_WB_CNT:
               state_r <= S_WB_STAT;
            S_WB_STAT:
               state_r <= S_IDLE;
            default:
               state_r <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Handshake, completion and stall event outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hs_r          <= '0;
         stall_event_r <= 1'b0;
         trn_done_r    <= 1'b0;
         trn_status_r  <= BYTE_ZERO;
      end
      else
      begin
         hs_r.valid    <= hs_raw && hshk_on && !bus_reset;
         hs_r.pid      <= hs_code;
         stall_event_r <= stall_raw && hshk_on && !bus_reset;
         trn_done_r    <= (state_r == S_WB_STAT) && !bus_reset;
         if (state_r == S_WB_STAT)
            trn_status_r <= {1'b0, ep_r, dsc_r[0], 2'h0};
      end
   end

   // ---------------------------------------------------------------
   // IN data stream
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_valid_r <= 1'b0;
         tx_byte_r  <= BYTE_ZERO;
         tx_last_r  <= 1'b0;
         tx_zero_r  <= 1'b0;
         tx_data1_r <= 1'b0;
      end
      else if (bus_reset)
         tx_valid_r <= 1'b0;
      else if (state_r == S_IN_LOAD)
      begin
         tx_valid_r <= 1'b1;
         tx_byte_r  <= ram_rd(buf_r);
         tx_last_r  <= (max_r <= 10'h001);
         tx_zero_r  <= (max_r == 10'h000);
         tx_data1_r <= st_r[ST_TOG];
      end
      else if ((state_r == S_IN_SEND) && tx_ready)
      begin
         if (tx_last_r)
            tx_valid_r <= 1'b0;
         else
         begin
            // Byte read straight from RAM; buffer not locked
            tx_byte_r <= ram_rd(buf_r + {2'h0, nxt_idx});
            tx_last_r <= ((nxt_idx + 10'h001) >= max_r);
         end
      end
   end

   // ---------------------------------------------------------------
   // Endpoint control registers
   // ---------------------------------------------------------------
   generate
      for (genvar i = 0; i < NUM_EP; i++)
      begin : g_ep
         logic sel_wr;
         logic stall_set;
         assign sel_wr    = cpu_wr && (cpu_addr == EPC_FIRST + 12'(i));
         assign stall_set = stall_raw && hshk_on && (cur_ep == 4'(i));
         always_ff @(posedge clock or negedge reset_n)
         begin
            if (!reset_n)
               epc_r[i] <= EPC_RESET;
            else if (sel_wr)
            begin
               epc_r[i]            <= cpu_wdata[4:0];
               // Firmware clear loses to a stall in the same cycle
               epc_r[i][EPC_STALL] <= cpu_wdata[EPC_STALL] || stall_set;
            end
            else if (stall_set)
               epc_r[i][EPC_STALL] <= 1'b1;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Address and frame registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         device_address_r <= ADDR_RESET;
      else if (bus_reset)
         device_address_r <= ADDR_RESET;
      else if (addr_wr)
         device_address_r <= addr_wdata;
   end

   // Suspended engine clock: frame is frozen, hence unreliable
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         frame_number_low_r  <= BYTE_ZERO;
         frame_number_high_r <= BYTE_ZERO;
      end
      else if (sof_valid && !suspend_bit)
      begin
         frame_number_low_r  <= sof_frame[7:0];
         frame_number_high_r <= {5'h00, sof_frame[10:8]};
      end
   end

   // ---------------------------------------------------------------
   // CPU read port
   // ---------------------------------------------------------------
   // No ownership check: CPU may read what the engine owns
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         cpu_rdata_r <= BYTE_ZERO;
      else if (in_ram(cpu_addr))
         cpu_rdata_r <= ram[cpu_addr];
      else if ((cpu_addr >= EPC_FIRST) && (cpu_addr <= EPC_LAST) &&
               (int'(cpu_addr - EPC_FIRST) < NUM_EP))
         cpu_rdata_r <= {3'h0, epc_r[4'(cpu_addr - EPC_FIRST)]};
      else
         cpu_rdata_r <= BYTE_ZERO;
   end

endmodule : ubd_engine

`default_nettype wire

// ===== src/ubd_pkg.sv
// ---------------------------------------------------------------
// Endpoint and buffer descriptor constants
// ---------------------------------------------------------------
package ubd_pkg;

   // Memory map of the CPU data port
   localparam logic [11:0] RAM_FIRST     = 12'h000;
   localparam logic [11:0] RAM_LAST      = 12'hEBF;
   localparam int          RAM_SIZE      = 3776;
   localparam logic [11:0] TBL_BASE      = 12'h400;
   localparam logic [11:0] TBL_LAST      = 12'h4FF;
   localparam int          DSC_MAX_COUNT = 64;
   localparam int          TBL_MIN_BYTES = 8;
   localparam int          TBL_MAX_BYTES = 256;
   localparam logic [11:0] EPC_FIRST     = 12'hF26;
   localparam logic [11:0] EPC_LAST      = 12'hF35;
   localparam int          EP_COUNT      = 16;

   // Descriptor byte order inside its four-byte block
   localparam logic [1:0]  DSC_OFS_STAT  = 2'h0;
   localparam logic [1:0]  DSC_OFS_CNT   = 2'h1;
   localparam logic [1:0]  DSC_OFS_ADRL  = 2'h2;
   localparam logic [1:0]  DSC_OFS_ADRH  = 2'h3;

   // Endpoint control fields
   localparam int          EPC_HSHK      = 4;
   localparam int          EPC_CONDIS    = 3;
   localparam int          EPC_OUTEN     = 2;
   localparam int          EPC_INEN      = 1;
   localparam int          EPC_STALL     = 0;
   localparam logic [4:0]  EPC_RESET     = 5'h00;

   // Descriptor status fields
   localparam int          ST_OWN        = 7;
   localparam int          ST_TOG        = 6;
   localparam int          ST_TOGEN      = 3;
   localparam int          ST_BSTL       = 2;

   // Token and handshake identifiers
   localparam logic [3:0]  PID_OUT       = 4'h1;
   localparam logic [3:0]  PID_IN        = 4'h9;
   localparam logic [3:0]  PID_SETUP     = 4'hD;
   localparam logic [3:0]  PID_ACK       = 4'h2;
   localparam logic [3:0]  PID_NAK       = 4'hA;
   localparam logic [3:0]  PID_STALL     = 4'hE;

   localparam logic [6:0]  ADDR_RESET    = 7'h00;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;

   // Token as delivered by the packet layer
   typedef struct packed {
      logic [3:0] pid;
      logic [6:0] addr;
      logic [3:0] endp;
   } ubd_token_t;

   // Handshake sent back to the packet layer
   typedef struct packed {
      logic       valid;
      logic [3:0] pid;
   } ubd_hs_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_RX,
      S_IN_LOAD,
      S_IN_SEND,
      S_IN_WAIT,
      S_WB_CNT,
      S_WB_STAT
   } ubd_state_t;

endpackage : ubd_pkg

// ===== sim/ubd_engine_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// Port checker of the engine
// ----------------------------
module ubd_engine_asserts
   import ubd_pkg::*;
#(
   parameter int RAM_BYTES = RAM_SIZE,
   parameter int NUM_EP    = EP_COUNT
)
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        addr_wr,
   input wire logic [6:0]  addr_wdata,
   input wire logic [6:0]  device_address_r,
   input wire logic        bus_reset,
   input wire logic        suspend_bit,
   input wire logic        sof_valid,
   input wire logic [10:0] sof_frame,
   input wire logic [7:0]  frame_number_low_r,
   input wire logic [7:0]  frame_number_high_r,
   input wire logic        rx_end,
   input wire logic        rx_ok,
   input wire logic        tx_ready,
   input wire ubd_hs_t     hs_r,
   input wire logic        tx_valid_r,
   input wire logic [7:0]  tx_byte_r,
   input wire logic        trn_done_r,
   input wire logic        stall_event_r
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   a_addr_bus_reset: assert property (bus_reset |=> device_address_r == ADDR_RESET)
      else $error("address survived bus reset");
   a_addr_load: assert property (addr_wr && !bus_reset |=> device_address_r == $past(addr_wdata))
      else $error("address write lost");
   a_frame_load: assert property (sof_valid && !suspend_bit |=>
      {frame_number_high_r, frame_number_low_r} == {5'h00, $past(sof_frame)})
      else $error("frame number not loaded");
   a_frame_hold: assert property (!sof_valid || suspend_bit |=>
      $stable(frame_number_low_r) && $stable(frame_number_high_r))
      else $error("frame number changed without SOF");
   a_crc_silent: assert property (rx_end && !rx_ok |=> !hs_r.valid)
      else $error("handshake after corrupt packet");
   a_stall_flag: assert property (hs_r.valid && hs_r.pid == PID_STALL |-> stall_event_r)
      else $error("STALL sent without stall event");
   a_hs_pulse: assert property (hs_r.valid |=> !hs_r.valid)
      else $error("handshake longer than one cycle");
   a_tx_hold: assert property (tx_valid_r && !tx_ready && !bus_reset |=>
      tx_valid_r && $stable(tx_byte_r))
      else $error("IN byte dropped before taken");

   // Main scenarios reached
   c_done: cover property (trn_done_r);
   c_stall: cover property (stall_event_r);
   c_nak: cover property (hs_r.valid && hs_r.pid == PID_NAK);
endmodule : ubd_engine_asserts

bind ubd_engine ubd_engine_asserts #(.RAM_BYTES(RAM_BYTES), .NUM_EP(NUM_EP)) u_chk (.*);
`default_nettype wire

// ===== sim/ubd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// Host across the bus
// ----------------------------
module ubd_host_model
   import ubd_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       tx_valid_r,
   input  wire logic [7:0] tx_byte_r,
   input  wire logic       tx_last_r,
   output var  logic       tok_valid,
   output var  ubd_token_t tok,
   output var  logic       rx_start,
   output var  logic       rx_data1,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_byte,
   output var  logic       rx_end,
   output var  logic       rx_ok,
   output var  logic       tx_ready,
   output var  logic       in_ack,
   output var  logic       in_timeout
);
   // Idle bus, no timeouts raised
   initial
   begin
      {tok_valid, rx_start, rx_data1, rx_valid, rx_end, rx_ok} = 6'h00;
      {tx_ready, in_ack, in_timeout, rx_byte, tok} = '0;
   end

   task automatic token(input logic [3:0] p, input logic [6:0] a, input logic [3:0] e);
      @(posedge clock);
      #1 tok_valid = 1'h1;
      tok = '{pid: p, addr: a, endp: e};
      @(posedge clock);
      #1 tok_valid = 1'h0;
      tok = ~tok;
   endtask : token

   // Released lines show the inverse
   task automatic data(input logic d1, input logic ok, input logic [7:0] q[$]);
      @(posedge clock);
      #1 rx_start = 1'h1;
      rx_data1 = d1;
      foreach (q[i])
      begin
         @(posedge clock);
         #1 rx_start = 1'h0;
         rx_valid = 1'h1;
         rx_byte = q[i];
      end
      @(posedge clock);
      #1 {rx_start, rx_valid, rx_end, rx_ok} = {2'h0, 1'h1, ok};
      @(posedge clock);
      #1 rx_end = 1'h0;
      rx_ok = ~ok;
      rx_byte = ~rx_byte;
   endtask : data

   // Drains IN data, stalling by the mask
   task automatic collect(input logic [7:0] m, output logic [7:0] q[$]);
      logic done;
      done = 1'h0;
      q = {};
      for (int i = 0; i < 200 && !done; i++)
      begin
         @(posedge clock);
         #1 tx_ready = m[i % 8];
         if (tx_valid_r && tx_ready)
         begin
            q.push_back(tx_byte_r);
            done = tx_last_r;
         end
      end
      @(posedge clock);
      #1 tx_ready = 1'h0;
   endtask : collect

   task automatic ack;
      @(posedge clock);
      #1 in_ack = 1'h1;
      @(posedge clock);
      #1 in_ack = 1'h0;
   endtask : ack
endmodule : ubd_host_model
`default_nettype wire

// ===== sim/test_ubd_engine.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// Bench of the endpoint engine
// ----------------------------
module test_ubd_engine;
   import ubd_pkg::*;
   logic        clock = 1'h0, reset_n = 1'h0, cpu_wr = 1'h0, addr_wr = 1'h0;
   logic        bus_reset = 1'h0, suspend_bit = 1'h0, sof_valid = 1'h0;
   logic [11:0] cpu_addr = 12'h000;
   logic [10:0] sof_frame = 11'h000, fr;
   logic [7:0]  cpu_wdata = 8'h00, cpu_rdata_r, frame_number_low_r, frame_number_high_r;
   logic [7:0]  rx_byte, tx_byte_r, trn_status_r, mem [int];
   logic [6:0]  addr_wdata = 7'h00, device_address_r, da;
   logic        tok_valid, rx_start, rx_data1, rx_valid, rx_end, rx_ok, tx_ready, in_ack;
   logic        in_timeout, tx_valid_r, tx_last_r, tx_zero_r, tx_data1_r, trn_done_r;
   logic        stall_event_r;
   logic [3:0]  hs_pid;
   logic [11:0] tbl [5] = '{12'h061, 12'h121, 12'h1ED, 12'h1E1, 12'h149};
   ubd_token_t  tok;
   ubd_hs_t     hs_r;
   int          miscompares = 0, checked = 0, seed = 71, hs_n = 0, done_n = 0, tn = 0;

   ubd_engine dut (.*);
   ubd_host_model host (.*);

   always #20 clock = ~clock;

   // Counts handshakes and completions, pulses last one cycle
   always @(posedge clock)
   begin
      if (hs_r.valid === 1'h1)
      begin
         hs_n <= hs_n + 1;
         hs_pid <= hs_r.pid;
      end
      if (trn_done_r === 1'h1)
         done_n <= done_n + 1;
   end

   function automatic logic [7:0] mv(input logic [11:0] a);
      return mem.exists(a) ? mem[a] : 8'h00;
   endfunction : mv

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Unmapped bits and addresses drop writes
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 {cpu_addr, cpu_wdata, cpu_wr} = {a, d, 1'h1};
      if (a <= 12'hEBF)
         mem[a] = d;
      else if (a inside {[12'hF26:12'hF35]})
         mem[a] = {3'h0, d[4:0]};
      @(posedge clock);
      #1 cpu_wr = 1'h0;
   endtask : wr

   task automatic rc(input logic [11:0] a);
      @(posedge clock);
      #1 cpu_addr = a;
      @(posedge clock);
      #1 chk(cpu_rdata_r, mv(a));
   endtask : rc

   task automatic arm(input logic [11:0] sa, input logic [7:0] n, input logic [11:0] ba,
                      input logic [7:0] st);
      wr(sa + 12'h001, n);
      wr(sa + 12'h002, ba[7:0]);
      wr(sa + 12'h003, {4'h0, ba[11:8]});
      wr(sa, st); // Status last, never half a descriptor
   endtask : arm

   // One endpoint-1 transaction against the model
   task automatic xfer(input logic [3:0] pid, input logic d1, input int n, input logic ok,
                       input logic [6:0] ad);
      logic [7:0]  s, c, ctl, q[$], got[$];
      logic [11:0] sa, ba;
      logic [4:0]  eh;
      logic        acc, stl, cm, wb;
      int          h0, d0, lim;
      {h0, d0} = {hs_n, done_n};
      sa = (pid == PID_IN) ? 12'h40C : 12'h408;
      {s, c, ctl} = {mv(sa), mv(sa + 12'h001), mv(12'hF27)};
      ba = 12'({mv(sa + 12'h003), mv(sa + 12'h002)});
      lim = {s[1:0], c};
      acc = ad == da && (pid == PID_IN ? ctl[1] : ctl[2] && (pid == PID_OUT || !(ctl[3] && ctl[1])));
      stl = s[2] && pid != PID_SETUP;
      eh = !s[7] ? {1'h1, PID_NAK} : stl ? {1'h1, PID_STALL} : pid == PID_IN ? 5'h00 :
           n > lim ? {1'h1, PID_NAK} : {1'h1, PID_ACK};
      eh = (acc && ok && ctl[4]) ? eh : 5'h00;
      wb = acc && ok && s[7] && !stl && pid != PID_IN && (pid == PID_SETUP || !s[3] || d1 == s[6]);
      cm = acc && ok && s[7] && !stl && (pid == PID_IN || (wb && n <= lim));
      host.token(pid, ad, 4'h1);
      if (pid != PID_IN)
      begin
         repeat (n) q.push_back(8'($random(seed)));
         host.data(d1, ok, q);
      end
      else if (cm)
      begin
         host.collect(8'($random(seed)) | 8'h01, got);
         chk(8'(got.size()), c);
         foreach (got[i]) chk(got[i], mv(ba + 12'(i)));
         chk({6'h0, tx_zero_r, tx_data1_r}, {6'h0, c == 8'h00, s[6]});
         host.ack();
      end
      repeat (6) @(posedge clock);
      if (wb) foreach (q[i]) if (i < lim) mem[ba + 12'(i)] = q[i];
      if (eh == {1'h1, PID_STALL}) mem[12'hF27] = ctl | 8'h01;
      if (cm) mem[sa] = {1'h0, s[6], pid, pid == PID_IN ? s[1:0] : 2'(n >> 8)};
      if (cm && pid != PID_IN) mem[sa + 12'h001] = 8'(n);
      chk(8'(hs_n - h0), {7'h0, eh[4]});
      if (eh[4]) chk({4'h0, hs_pid}, {4'h0, eh[3:0]});
      chk(8'(done_n - d0), {7'h0, cm});
      if (cm) chk(trn_status_r, {3'h0, 4'h1, pid == PID_IN, 2'h0});
      rc(sa);
      rc(sa + 12'h001);
      rc(12'hF27);
      foreach (q[i]) if (i < lim && mem.exists(ba + 12'(i))) rc(ba + 12'(i));
   endtask : xfer

   task automatic tend;
      tn++;
      $display("test %0d ended, mismatches %0d", tn, miscompares);
   endtask : tend

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // Hang guard, far past the test length
   initial
   begin
      #2000000;
      miscompares++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      repeat (2) @(posedge clock);
      #1 reset_n = 1'h1;
      rc(12'hF26);
      rc(12'hF35);
      wr(12'hF30, 8'hFF);
      rc(12'hF30);
      rc(12'hF40);
      tend();
      @(posedge clock);
      #1 {addr_wr, addr_wdata, da} = {1'h1, 7'h05, 7'h05};
      @(posedge clock);
      #1 addr_wr = 1'h0;
      wr(12'hF27, 8'h16);
      arm(12'h408, 8'h04, 12'h500, 8'h88);
      xfer(PID_OUT, 1'h0, 3, 1'h1, 7'h06);
      xfer(PID_OUT, 1'h0, 3, 1'h1, da);
      arm(12'h408, 8'h04, 12'h500, 8'h88);
      xfer(PID_OUT, 1'h1, 2, 1'h1, da);
      arm(12'h408, 8'h02, 12'h520, 8'h80);
      xfer(PID_OUT, 1'h0, 3, 1'h1, da);
      arm(12'h408, 8'h04, 12'h540, 8'h80);
      xfer(PID_OUT, 1'h0, 2, 1'h0, da);
      xfer(PID_OUT, 1'h0, 4, 1'h1, da);
      arm(12'h408, 8'h08, 12'h560, 8'h8C);
      xfer(PID_OUT, 1'h0, 1, 1'h1, da);
      xfer(PID_SETUP, 1'h1, 2, 1'h1, da);
      tend();
      for (int i = 0; i < 4; i++) wr(12'h600 + 12'(i), 8'($random(seed)));
      arm(12'h40C, 8'h04, 12'h600, 8'h80);
      xfer(PID_IN, 1'h0, 0, 1'h1, da);
      xfer(PID_IN, 1'h0, 0, 1'h1, da);
      tend();
      // No handshake, direction off, SETUP refused, OUT on non-control endpoint taken, IN refused
      foreach (tbl[k])
      begin
         wr(12'hF27, tbl[k][11:4]);
         arm(12'h408, 8'h04, 12'h580, 8'h80);
         arm(12'h40C, 8'h04, 12'h600, 8'h80);
         xfer(tbl[k][3:0], 1'h0, 2, 1'h1, da);
      end
      tend();
      fr = 11'($random(seed));
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clock);
         #1 {suspend_bit, sof_valid, sof_frame} = {k[0], 1'h1, fr ^ {11{k[0]}}};
         @(posedge clock);
         #1 sof_valid = 1'h0;
         chk(frame_number_low_r, fr[7:0]);
         chk(frame_number_high_r, {5'h00, fr[10:8]});
      end
      suspend_bit = 1'h0;
      @(posedge clock);
      #1 bus_reset = 1'h1;
      @(posedge clock);
      #1 {bus_reset, da} = {1'h0, 7'h00};
      chk({1'h0, device_address_r}, 8'h00);
      xfer(PID_OUT, 1'h0, 1, 1'h1, 7'h05);
      tend();
      give_verdict();
   end
endmodule : test_ubd_engine
`default_nettype wire
